/* File: logic/bfeu_cfg.svh */
// constants for the bit-field and extend unit
// assumes inclusion by bare name from the unit's package and module
`ifndef BFEU_CFG_SVH
`define BFEU_CFG_SVH
`define BFEU_DATA_W      32
`define BFEU_POS_W       5
`define BFEU_WID_W       6
`define BFEU_BYTE_W      8
`define BFEU_HALF_W      16
`define BFEU_FLAGS_W     5
`define BFEU_RESULT_RST  32'h0000_0000
`define BFEU_FLAGS_RST   5'h00
`endif

/* File: logic/bfeu_pkg.sv */
// types for the bit-field and extend unit
// assumes bfeu_cfg.svh is on the include path
`include "bfeu_cfg.svh"
package bfeu_pkg;
  typedef enum logic [2:0] {
    field_clear_op            = 3'h0,
    field_insert_op           = 3'h1,
    signed_field_extract_op   = 3'h2,
    unsigned_field_extract_op = 3'h3,
    sign_extend_byte_op       = 3'h4,
    sign_extend_half_op       = 3'h5,
    zero_extend_byte_op       = 3'h6,
    zero_extend_half_op       = 3'h7
  } bfeu_op_t;

  typedef struct packed {
    logic [`BFEU_DATA_W-1:0]  result;
    logic                     valid;
    logic [`BFEU_FLAGS_W-1:0] flags;
  } bfeu_state_t;
endpackage

/* File: logic/bfeu_unit.sv */
// bit-field clear/insert/extract and byte/halfword extend unit
// assumes decoder presents legal operands with issue_in for one cycle
//
// Summary of operation
// RL1 - field clear zeroes width bits from lsb
// RL2 - field insert copies low source bits in
// RL3 - issuer keeps lsb within 0 to 31
// RL4 - issuer keeps width within 1 to 32-lsb
// RL5 - signed extract replicates field top bit
// RL6 - unsigned extract zero pads the field
// RL7 - extend operand rotated right 0/8/16/24
// RL8 - signed byte extend copies bit 7
// RL9 - unsigned byte extend clears upper bits
// RL10 - signed half extend copies bit 15
// RL11 - unsigned half extend clears upper bits
// RL12 - condition flags pass through unchanged
// RL13 - issuer never names stack pointer or pc
// RL14 - illegal field gives any result, no fault
`timescale 1ns/1ps
`default_nettype none
`include "bfeu_cfg.svh"
module bfeu_unit #(
  parameter int DATA_W = `BFEU_DATA_W
) (
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  input  wire logic                     clk_en_in,
  input  wire logic                     issue_in,
  input  wire bfeu_pkg::bfeu_op_t       op_in,
  input  wire logic [`BFEU_POS_W-1:0]   lsb_in,
  input  wire logic [`BFEU_WID_W-1:0]   width_in,
  input  wire logic [1:0]               rot_in,
  input  wire logic [DATA_W-1:0]        dest_in,
  input  wire logic [DATA_W-1:0]        source_operand_in,
  input  wire logic [DATA_W-1:0]        extend_operand_in,
  input  wire logic [`BFEU_FLAGS_W-1:0] flags_in,
  output logic [DATA_W-1:0]             result_out,
  output logic                          result_valid_out,
  output logic [`BFEU_FLAGS_W-1:0]      flags_out
);
  bfeu_pkg::bfeu_state_t state_r;
  bfeu_pkg::bfeu_state_t state_nxt;

  logic [DATA_W-1:0] field_mask;
  logic [DATA_W-1:0] low_mask;
  logic [DATA_W-1:0] shifted_src;
  logic [DATA_W-1:0] rotated;
  logic [DATA_W-1:0] calc;
  logic [5:0]        top_pos;
  logic              field_sign;

  // one bit of the field masks per position
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_mask
      assign low_mask[gi]   = (7'(gi) < {1'b0, width_in});
      assign field_mask[gi] = (7'(gi) >= {2'b00, lsb_in}) &&
                              (7'(gi) < (7'(lsb_in) + 7'(width_in)));
    end
  endgenerate

  // out-of-range fields just produce garbage, never a fault
  assign top_pos     = 6'(lsb_in) + width_in - 6'h01; // RL14
  assign shifted_src = source_operand_in >> lsb_in;
  assign field_sign  = source_operand_in[top_pos[4:0]];
  assign rotated     = (extend_operand_in >> {rot_in, 3'b000}) |
                       (extend_operand_in << (6'h20 - {1'b0, rot_in, 3'b000})); // RL7

  // single combinational process: pick the result, then fill the state copy
  always_comb
  begin
    calc      = '0;
    state_nxt = state_r;
    unique case (op_in)
      bfeu_pkg::field_clear_op:
      begin
        calc = dest_in & ~field_mask; // RL1
      end
      bfeu_pkg::field_insert_op:
      begin
        calc = (dest_in & ~field_mask) |
               ((source_operand_in << lsb_in) & field_mask); // RL2
      end
      bfeu_pkg::signed_field_extract_op:
      begin
        calc = (shifted_src & low_mask) | ({DATA_W{field_sign}} & ~low_mask); // RL5
      end
      bfeu_pkg::unsigned_field_extract_op:
      begin
        calc = shifted_src & low_mask; // RL6
      end
      bfeu_pkg::sign_extend_byte_op:
      begin
        calc = {{(DATA_W-8){rotated[7]}}, rotated[7:0]}; // RL8
      end
      bfeu_pkg::sign_extend_half_op:
      begin
        calc = {{(DATA_W-16){rotated[15]}}, rotated[15:0]}; // RL10
      end
      bfeu_pkg::zero_extend_byte_op:
      begin
        calc = {{(DATA_W-8){1'b0}}, rotated[7:0]}; // RL9
      end
      bfeu_pkg::zero_extend_half_op:
      begin
        calc = {{(DATA_W-16){1'b0}}, rotated[15:0]}; // RL11
      end
    endcase
    state_nxt.valid = issue_in;
    // flags copied, never computed here
    state_nxt.flags = flags_in; // RL12
    // result holds between issues so a late reader still sees it
    if (issue_in)
    begin
      state_nxt.result = calc;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r.result <= `BFEU_RESULT_RST;
      state_r.valid  <= 1'b0;
      state_r.flags  <= `BFEU_FLAGS_RST;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
    end
  end

  assign result_out       = state_r.result;
  assign result_valid_out = state_r.valid;
  assign flags_out        = state_r.flags;

  // checker-only references: masks and rotation rebuilt by plain shifts,
  // so the assertions below do not lean on the bit loop they guard
  logic [DATA_W-1:0] chk_low;
  logic [DATA_W-1:0] chk_field;
  logic [DATA_W-1:0] chk_src_dn;
  logic [DATA_W-1:0] chk_rot;
  logic              chk_sign;

  // one extra bit so a full-width field does not wrap to zero
  assign chk_low    = DATA_W'(({{DATA_W{1'b0}}, 1'b1} << width_in) -
                              {{DATA_W{1'b0}}, 1'b1});
  assign chk_field  = chk_low << lsb_in;
  assign chk_src_dn = source_operand_in >> lsb_in;
  // doubled word shifted right is a rotate without wrap logic
  assign chk_rot    = DATA_W'({extend_operand_in, extend_operand_in} >> {rot_in, 3'b000});
  // top bit of the low mask picks the field's sign bit
  assign chk_sign   = |(chk_src_dn & (chk_low ^ (chk_low >> 1)));

  chk_clear_field: assert property (@(posedge mclk_in) disable iff (rst_in) // RL1
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::field_clear_op
    |=> result_out == ($past(dest_in) & ~$past(chk_field)))
    else $error("field clear result wrong");

  chk_clear_full: assert property (@(posedge mclk_in) disable iff (rst_in) // RL1
    clk_en_in && issue_in && op_in == bfeu_pkg::field_clear_op &&
    lsb_in == 5'h00 && width_in == 6'h20
    |=> result_out == '0)
    else $error("full width clear left bits set");

  chk_insert_keep: assert property (@(posedge mclk_in) disable iff (rst_in) // RL2
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::field_insert_op
    |=> ((result_out ^ $past(dest_in)) & ~$past(chk_field)) == '0)
    else $error("field insert touched outside bits");

  chk_insert_bits: assert property (@(posedge mclk_in) disable iff (rst_in) // RL2
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::field_insert_op
    |=> (result_out & $past(chk_field)) ==
        (($past(source_operand_in) & $past(chk_low)) << $past(lsb_in)))
    else $error("field insert bits wrong");

  chk_sext_top: assert property (@(posedge mclk_in) disable iff (rst_in) // RL5
    clk_en_in && issue_in && width_in == 6'h01 &&
    op_in == bfeu_pkg::signed_field_extract_op
    |=> result_out == {DATA_W{$past(chk_sign)}})
    else $error("signed extract sign wrong");

  chk_sext_body: assert property (@(posedge mclk_in) disable iff (rst_in) // RL5
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::signed_field_extract_op
    |=> (result_out & $past(chk_low)) == ($past(chk_src_dn) & $past(chk_low)))
    else $error("signed extract field bits wrong");

  chk_sext_fill: assert property (@(posedge mclk_in) disable iff (rst_in) // RL5
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::signed_field_extract_op
    |=> (result_out & ~$past(chk_low)) == ({DATA_W{$past(chk_sign)}} & ~$past(chk_low)))
    else $error("signed extract fill wrong");

  chk_zext_field: assert property (@(posedge mclk_in) disable iff (rst_in) // RL6
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::unsigned_field_extract_op
    |=> (result_out & ~$past(chk_low)) == '0)
    else $error("unsigned extract upper bits set");

  chk_zext_body: assert property (@(posedge mclk_in) disable iff (rst_in) // RL6
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::unsigned_field_extract_op
    |=> result_out == ($past(chk_src_dn) & $past(chk_low)))
    else $error("unsigned extract value wrong");

  chk_zext_whole: assert property (@(posedge mclk_in) disable iff (rst_in) // RL6
    clk_en_in && issue_in && lsb_in == 5'h00 && width_in == 6'h20 &&
    op_in == bfeu_pkg::unsigned_field_extract_op
    |=> result_out == $past(source_operand_in))
    else $error("whole word extract changed value");

  // fixed rotations checked against plain slices of the operand, the byte case against chk_rot at any rotation
  chk_rot_none: assert property (@(posedge mclk_in) disable iff (rst_in) // RL7
    clk_en_in && issue_in && rot_in == 2'b00 &&
    op_in == bfeu_pkg::zero_extend_half_op
    |=> result_out == {{(DATA_W-16){1'b0}}, $past(extend_operand_in[15:0])})
    else $error("zero rotation changed operand");

  chk_rot_byte: assert property (@(posedge mclk_in) disable iff (rst_in) // RL7
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::zero_extend_byte_op
    |=> result_out[7:0] == $past(chk_rot[7:0]))
    else $error("byte rotation wrong");

  chk_rot_half: assert property (@(posedge mclk_in) disable iff (rst_in) // RL7
    clk_en_in && issue_in && rot_in == 2'b10 &&
    op_in == bfeu_pkg::sign_extend_half_op
    |=> result_out[15:0] == $past(extend_operand_in[31:16]))
    else $error("half rotation wrong");

  chk_rot_top: assert property (@(posedge mclk_in) disable iff (rst_in) // RL7
    clk_en_in && issue_in && rot_in == 2'b11 &&
    op_in == bfeu_pkg::sign_extend_byte_op
    |=> result_out[7:0] == $past(extend_operand_in[31:24]))
    else $error("top byte rotation wrong");

  chk_sbyte: assert property (@(posedge mclk_in) disable iff (rst_in) // RL8
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::sign_extend_byte_op
    |=> result_out[DATA_W-1:8] == {(DATA_W-8){result_out[7]}})
    else $error("byte sign extend wrong");

  chk_sbyte_low: assert property (@(posedge mclk_in) disable iff (rst_in) // RL8
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::sign_extend_byte_op
    |=> result_out[7:0] == $past(chk_rot[7:0]))
    else $error("byte sign extend low bits wrong");

  chk_ubyte: assert property (@(posedge mclk_in) disable iff (rst_in) // RL9
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::zero_extend_byte_op
    |=> result_out == {24'h00_0000, $past(chk_rot[7:0])})
    else $error("byte zero extend wrong");

  chk_shalf: assert property (@(posedge mclk_in) disable iff (rst_in) // RL10
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::sign_extend_half_op
    |=> result_out == {{16{$past(chk_rot[15])}}, $past(chk_rot[15:0])})
    else $error("half sign extend wrong");

  chk_uhalf: assert property (@(posedge mclk_in) disable iff (rst_in) // RL11
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::zero_extend_half_op
    |=> result_out[DATA_W-1:16] == 16'h0000)
    else $error("half zero extend wrong");

  chk_uhalf_low: assert property (@(posedge mclk_in) disable iff (rst_in) // RL11
    clk_en_in && issue_in &&
    op_in == bfeu_pkg::zero_extend_half_op
    |=> result_out[15:0] == $past(chk_rot[15:0]))
    else $error("half zero extend low bits wrong");

  chk_flags_pass: assert property (@(posedge mclk_in) disable iff (rst_in) // RL12
    clk_en_in |=> flags_out == $past(flags_in))
    else $error("flags altered");

  // enable low freezes every output
  chk_flags_hold: assert property (@(posedge mclk_in) disable iff (rst_in) // RL12
    !clk_en_in |=> $stable(flags_out))
    else $error("flags moved while frozen");

  chk_frozen_state: assert property (@(posedge mclk_in) disable iff (rst_in)
    !clk_en_in |=> $stable(result_out) && $stable(result_valid_out))
    else $error("result moved while frozen");

  chk_idle_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    clk_en_in && !issue_in |=> $stable(result_out) && !result_valid_out)
    else $error("result moved without issue");

  chk_issue_answer: assert property (@(posedge mclk_in) disable iff (rst_in) // RL14
    clk_en_in && issue_in |=> result_valid_out)
    else $error("issue got no answer");
endmodule // bfeu_unit
`default_nettype wire

/* File: test/bfeu_issuer.sv */
// issuer model: decoder and register file feeding the unit
// assumes the bench clock; drives legal fields at the falling edge
`timescale 1ns/1ps
`default_nettype none
module bfeu_issuer (
  input  wire logic          mclk_in,
  input  wire logic          run_in,
  output var bfeu_pkg::bfeu_op_t op_out,
  output logic [4:0]         lsb_out,
  output logic [5:0]         width_out,
  output logic [1:0]         rot_out,
  output logic [95:0]        regs_out,
  output logic               issue_out
);
  int l;
  initial
  begin
    op_out = bfeu_pkg::field_clear_op;
    {lsb_out, width_out, rot_out, regs_out, issue_out} = '0;
  end
  always @(negedge mclk_in)
  begin
    // bias towards top position and widest field for edge cases
    l = ($urandom % 4 == 0) ? 31 : $urandom_range(0, 31);
    op_out <= bfeu_pkg::bfeu_op_t'($urandom_range(0, 7));
    lsb_out <= 5'(l);
    width_out <= 6'(($urandom % 2) ? 32 - l : $urandom_range(1, 32 - l));
    rot_out <= 2'($urandom);
    regs_out <= {$urandom, $urandom, $urandom};
    issue_out <= run_in && ($urandom % 4 != 0);
  end
endmodule // bfeu_issuer
`default_nettype wire

/* File: test/bitfield_extend_unit_tb.sv */
// bench: random issue stream checked against a reference model
// assumes the unit answers one enabled cycle after each issue
`timescale 1ns/1ps
`default_nettype none
module bitfield_extend_unit_tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic run = 1'b0;
  logic [4:0] flags_in = 5'h00;
  bfeu_pkg::bfeu_op_t op;
  logic [4:0] lsb;
  logic [5:0] width;
  logic [1:0] rot;
  logic [95:0] regs;
  logic [31:0] result_out, exp_res;
  logic issue, result_valid_out, exp_valid;
  logic [4:0] flags_out, exp_flags;
  int err_total = 0;
  int checks_done = 0;
  always #2.5 mclk_in = ~mclk_in;
  bfeu_issuer u_iss (.mclk_in(mclk_in), .run_in(run), .op_out(op), .lsb_out(lsb),
    .width_out(width), .rot_out(rot), .regs_out(regs), .issue_out(issue));
  bfeu_unit DUT (.mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .issue_in(issue), .op_in(op), .lsb_in(lsb), .width_in(width), .rot_in(rot),
    .dest_in(regs[95:64]), .source_operand_in(regs[63:32]), .extend_operand_in(regs[31:0]),
    .flags_in(flags_in), .result_out(result_out), .result_valid_out(result_valid_out),
    .flags_out(flags_out));
  function automatic logic [31:0] ref_calc(input int o, l, w, r, input logic [31:0] d, s, e);
    logic [31:0] m, f, x;
    m = 32'((33'h0_0000_0001 << w) - 1);
    f = (s >> l) & m;
    x = (e >> (8 * r)) | (e << (32 - 8 * r));
    case (o)
      0: return d & ~(m << l);
      1: return (d & ~(m << l)) | ((s & m) << l);
      2: return s[l + w - 1] ? f | ~m : f;
      3: return f;
      4: return {{24{x[7]}}, x[7:0]};
      5: return {{16{x[15]}}, x[15:0]};
      6: return {24'h00_0000, x[7:0]};
      default: return {16'h0000, x[15:0]};
    endcase
  endfunction
  always @(posedge mclk_in or posedge rst_in)
    if (rst_in)
      {exp_res, exp_valid, exp_flags} = '0;
    else if (clk_en_in)
    begin
      exp_valid = issue;
      exp_flags = flags_in;
      if (issue)
        exp_res = ref_calc(int'(op), lsb, width, rot, regs[95:64], regs[63:32], regs[31:0]);
    end
  task automatic bad(input string n, input logic [31:0] e, g);
    err_total++;
    $display("BAD %s expected %h seen %h", n, e, g);
  endtask
  task automatic cmp_res();
    checks_done++;
    if (result_out !== exp_res) bad("result", exp_res, result_out);
  endtask
  task automatic cmp_valid();
    checks_done++;
    if (result_valid_out !== exp_valid) bad("valid", 32'(exp_valid), 32'(result_valid_out));
  endtask
  task automatic cmp_flags();
    checks_done++;
    if (flags_out !== exp_flags) bad("flags", 32'(exp_flags), 32'(flags_out));
  endtask
  always @(negedge mclk_in)
  begin
    cmp_res();
    cmp_valid();
    cmp_flags();
    clk_en_in <= ($urandom % 8) != 0;
    flags_in <= 5'($urandom);
  end
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h0000_bf64));
    repeat (10) @(negedge mclk_in);
    // non-blocking so the compare at this edge still sees in-reset values
    rst_in <= 1'b0;
    run <= 1'b1;
    repeat (3000) @(negedge mclk_in);
    // reset again in mid-stream
    rst_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    rst_in <= 1'b0;
    repeat (1000) @(negedge mclk_in);
    give_verdict();
  end
  initial
  begin
    #100_000;
    err_total++;
    give_verdict();
  end
endmodule // bitfield_extend_unit_tb
`default_nettype wire
